// ---- core/twowire_slave.sv ----
/*
  two-wire bus slave end: framing, address match, byte in/out, stretching.
  assumes scl/sda sampled on a free-running link clock, user side on clk.
*/
`timescale 1ns/1ps
`default_nettype none
module twowire_slave
  import twowire_pkg::*;
#(
  parameter logic [6:0] OWN_ADDR = DEF_ADDR
)
(
  // clocks and reset
  input wire logic clk,
  input wire logic linkClk,
  input wire logic rst,
  // user side, clk domain
  input wire logic asleep,
  input wire logic rxAck,
  input wire logic txLoad,
  input wire logic [7:0] txByte,
  output logic txFree,
  output logic rxValid,
  output logic [7:0] rxByte,
  output logic busy,
  // bus
  twowire_if.device bus
);
  typedef enum logic [3:0] {L_IDLE, L_WAKE, L_ADDR, L_AACK, L_RX, L_RACK,
    L_WAITTX, L_TX, L_TACK} lst_t;
  // link-domain state
  typedef struct packed {
    logic rstM;
    logic rstS;
    logic sclM;
    logic sclS;
    logic sdaM;
    logic sdaS;
    logic sclPrev;
    logic sdaPrev;
    logic sleepM;
    logic sleepS;
    logic ackM;
    logic ackS;
    logic txTogM;
    logic txTogS;
    logic txSeen;
    lst_t st;
    logic [3:0] bitCnt;
    logic [7:0] shift;
    logic rw;
    logic mAck;
    logic sdaLow;
    logic sclLow;
    logic [CNT_W-1:0] wake;
    logic [7:0] rxHold;
    logic rxTog;
    logic takenTog;
    logic busy;
  } lstate_t;
  // clk-domain state
  typedef struct packed {
    logic rxTogM;
    logic rxTogS;
    logic rxSeen;
    logic takenM;
    logic takenS;
    logic takenSeen;
    logic busyM;
    logic busyS;
    logic txTog;
    logic [7:0] txData;
    logic txFree;
    logic rxValid;
    logic [7:0] rxByte;
  } sstate_t;
  lstate_t l_r;
  lstate_t l_nxt;
  sstate_t s_r;
  sstate_t s_nxt;
  logic sclRise;
  logic sclFall;
  logic startC;
  logic stopC;
  logic txFresh;
  // bus events from second-stage samples only
  assign sclRise = l_r.sclS & ~l_r.sclPrev;
  assign sclFall = ~l_r.sclS & l_r.sclPrev;
  assign startC = l_r.sclS & l_r.sclPrev & l_r.sdaPrev & ~l_r.sdaS;
  assign stopC = l_r.sclS & l_r.sclPrev & ~l_r.sdaPrev & l_r.sdaS;
  assign txFresh = l_r.txTogS != l_r.txSeen;
  // link-domain next state
  always_comb
  begin
    l_nxt = l_r;
    l_nxt.rstM = rst;
    l_nxt.rstS = l_r.rstM;
    l_nxt.sclM = bus.scl;
    l_nxt.sclS = l_r.sclM;
    l_nxt.sdaM = bus.sda;
    l_nxt.sdaS = l_r.sdaM;
    l_nxt.sclPrev = l_r.sclS;
    l_nxt.sdaPrev = l_r.sdaS;
    l_nxt.sleepM = asleep;
    l_nxt.sleepS = l_r.sleepM;
    l_nxt.ackM = rxAck;
    l_nxt.ackS = l_r.ackM;
    l_nxt.txTogM = s_r.txTog;
    l_nxt.txTogS = l_r.txTogM;
    if (l_r.rstS)
    begin
      l_nxt.txSeen = l_r.txTogS;
      l_nxt.st = L_IDLE;
      l_nxt.bitCnt = '0;
      l_nxt.shift = '0;
      l_nxt.rw = 1'b0;
      l_nxt.mAck = 1'b0;
      l_nxt.sdaLow = 1'b0;
      l_nxt.sclLow = 1'b0;
      l_nxt.wake = '0;
      l_nxt.rxHold = '0;
      l_nxt.rxTog = 1'b0;
      l_nxt.takenTog = 1'b0;
      l_nxt.busy = 1'b0;
    end
    else if (stopC)
    begin
      // end of transaction: release both lines
      l_nxt.st = L_IDLE;
      l_nxt.sdaLow = 1'b0;
      l_nxt.sclLow = 1'b0;
      l_nxt.busy = 1'b0;
    end
    else if (startC)
    begin
      // also a repeated start: a fresh address packet follows
      l_nxt.busy = 1'b1;
      l_nxt.bitCnt = '0;
      l_nxt.sdaLow = 1'b0;
      l_nxt.wake = '0;
      l_nxt.st = l_r.sleepS ? L_WAKE : L_ADDR;
    end
    else
    begin
      case (l_r.st)
        L_WAKE:
          // hold scl low only once it has been seen low
          if (!l_r.sclS || l_r.sclLow)
          begin
            l_nxt.sclLow = 1'b1;
            // count held cycles only, so the hold spans the full wake time
            if (l_r.sclLow)
              l_nxt.wake = l_r.wake + 1'b1;
            if (l_r.sclLow && l_r.wake == WAKE_LAST)
            begin
              l_nxt.sclLow = 1'b0;
              l_nxt.st = L_ADDR;
            end
          end
        L_ADDR, L_RX:
        begin
          if (sclRise)
          begin
            // msb first
            l_nxt.shift = {l_r.shift[6:0], l_r.sdaS};
            l_nxt.bitCnt = l_r.bitCnt + 1'b1;
          end
          if (sclFall && l_r.bitCnt == ACK_SLOT)
          begin
            if (l_r.st == L_ADDR)
            begin
              if (l_r.shift[7:1] == OWN_ADDR)
              begin
                l_nxt.sdaLow = 1'b1;
                l_nxt.rw = l_r.shift[0];
                l_nxt.st = L_AACK;
              end
              else
                l_nxt.st = L_IDLE;
            end
            else
            begin
              l_nxt.sdaLow = l_r.ackS;
              l_nxt.rxHold = l_r.shift;
              l_nxt.rxTog = ~l_r.rxTog;
              l_nxt.st = L_RACK;
            end
          end
        end
        L_AACK:
          if (sclFall)
          begin
            l_nxt.sdaLow = 1'b0;
            l_nxt.bitCnt = '0;
            l_nxt.st = l_r.rw ? L_WAITTX : L_RX;
          end
        L_RACK:
          if (sclFall)
          begin
            // after a nack only start or stop is expected
            l_nxt.sdaLow = 1'b0;
            l_nxt.bitCnt = '0;
            l_nxt.st = l_r.sdaLow ? L_RX : L_IDLE;
          end
        L_WAITTX:
          if (txFresh)
          begin
            l_nxt.shift = s_r.txData;
            l_nxt.txSeen = l_r.txTogS;
            l_nxt.takenTog = ~l_r.takenTog;
            l_nxt.sdaLow = ~s_r.txData[7];
            l_nxt.sclLow = 1'b0;
            l_nxt.bitCnt = '0;
            l_nxt.st = L_TX;
          end
          else
            l_nxt.sclLow = 1'b1;
        L_TX:
        begin
          if (sclRise)
            l_nxt.bitCnt = l_r.bitCnt + 1'b1;
          if (sclFall)
          begin
            if (l_r.bitCnt == ACK_SLOT)
            begin
              l_nxt.sdaLow = 1'b0;
              l_nxt.st = L_TACK;
            end
            else
            begin
              l_nxt.shift = {l_r.shift[6:0], 1'b0};
              l_nxt.sdaLow = ~l_r.shift[6];
            end
          end
        end
        L_TACK:
        begin
          if (sclRise)
            l_nxt.mAck = ~l_r.sdaS;
          if (sclFall)
            l_nxt.st = l_r.mAck ? L_WAITTX : L_IDLE;
        end
        default:
        begin
          l_nxt.st = L_IDLE;
          l_nxt.sdaLow = 1'b0;
          l_nxt.sclLow = 1'b0;
        end
      endcase
    end
  end
  // link-domain register
  always_ff @(posedge linkClk)
  begin
    l_r <= l_nxt;
  end
  // clk-domain next state: toggle handshakes with the link
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.rxTogM = l_r.rxTog;
    s_nxt.rxTogS = s_r.rxTogM;
    s_nxt.takenM = l_r.takenTog;
    s_nxt.takenS = s_r.takenM;
    s_nxt.busyM = l_r.busy;
    s_nxt.busyS = s_r.busyM;
    s_nxt.rxValid = 1'b0;
    if (rst)
    begin
      s_nxt.rxSeen = s_r.rxTogS;
      s_nxt.takenSeen = s_r.takenS;
      s_nxt.txTog = 1'b0;
      s_nxt.txData = '0;
      s_nxt.txFree = 1'b1;
      s_nxt.rxByte = '0;
    end
    else
    begin
      // received byte, held stable by the link until the next one
      if (s_r.rxTogS != s_r.rxSeen)
      begin
        s_nxt.rxSeen = s_r.rxTogS;
        s_nxt.rxByte = l_r.rxHold;
        s_nxt.rxValid = 1'b1;
      end
      // transmit word kept stable until the link takes it
      if (s_r.takenS != s_r.takenSeen)
      begin
        s_nxt.takenSeen = s_r.takenS;
        s_nxt.txFree = 1'b1;
      end
      if (txLoad && s_r.txFree)
      begin
        s_nxt.txData = txByte;
        s_nxt.txTog = ~s_r.txTog;
        s_nxt.txFree = 1'b0;
      end
    end
  end
  // clk-domain register
  always_ff @(posedge clk)
  begin
    s_r <= s_nxt;
  end
  // outputs; pins only ever pull low
  assign txFree = s_r.txFree;
  assign rxValid = s_r.rxValid;
  assign rxByte = s_r.rxByte;
  assign busy = s_r.busyS;
  assign bus.sclOutD = 1'b0;
  assign bus.sdaOutD = 1'b0;
  assign bus.sclOeD = l_r.sclLow;
  assign bus.sdaOeD = l_r.sdaLow;
endmodule
`default_nettype wire

// ---- core/twowire_pkg.sv ----
/*
  shared constants and types for the two-wire bus master and slave ends.
  assumes a 40 MHz system clock and an 80 ns link sampling clock.
*/
package twowire_pkg;
  // clock periods
  localparam int CLK_PERIOD_NS = 25;
  localparam int LINK_PERIOD_NS = 80;
  // slave wake-up hold, least time, rounded up on the link clock
  localparam int WAKE_NS = 2000;
  localparam int WAKE_CYC = (WAKE_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
  // master scl phases, least times, rounded up on clk
  localparam int T_LOW_NS = 4700;
  localparam int T_HIGH_NS = 4000;
  localparam int T_LOW_CYC = (T_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_HIGH_CYC = (T_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // counter width and terminal counts
  localparam int CNT_W = 12;
  localparam logic [CNT_W-1:0] WAKE_LAST = CNT_W'(WAKE_CYC - 1);
  localparam logic [CNT_W-1:0] LOW_LAST = CNT_W'(T_LOW_CYC - 1);
  localparam logic [CNT_W-1:0] HIGH_LAST = CNT_W'(T_HIGH_CYC - 1);
  // framing
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [7:0] IDLE_BYTE = 8'hff;
  localparam logic [6:0] DEF_ADDR = 7'h2a;
  // master byte commands
  typedef enum logic [1:0] {CMD_START, CMD_WRITE, CMD_READ, CMD_STOP} cmd_t;
endpackage

// ---- core/twowire_if.sv ----
/*
  open-drain scl/sda carrier between the master end and the slave end.
  assumes each end drives only low; the wire level is worked out here.
*/
`timescale 1ns/1ps
`default_nettype none
interface twowire_if;
  // per-end drivers
  logic sclOutM;
  logic sclOeM;
  logic sdaOutM;
  logic sdaOeM;
  logic sclOutD;
  logic sclOeD;
  logic sdaOutD;
  logic sdaOeD;
  logic scl;
  logic sda;
  // wired-and with pull-up rest level
  assign scl = ~((sclOeM & ~sclOutM) | (sclOeD & ~sclOutD));
  assign sda = ~((sdaOeM & ~sdaOutM) | (sdaOeD & ~sdaOutD));
  modport master (input scl, sda, output sclOutM, sclOeM, sdaOutM, sdaOeM);
  modport device (input scl, sda, output sclOutD, sclOeD, sdaOutD, sdaOeD);
endinterface
`default_nettype wire

// ---- core/twowire_master.sv ----
/*
  byte-command bus master: start, write, read, stop on the open-drain bus.
  assumes one command at a time on a valid/ready handshake, 40 MHz clk.
*/
`timescale 1ns/1ps
`default_nettype none
module twowire_master
  import twowire_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // command side
  input wire logic cmdValid,
  input wire twowire_pkg::cmd_t cmdKind,
  input wire logic [7:0] cmdData,
  input wire logic cmdLast,
  output logic cmdReady,
  output logic byteDone,
  output logic [7:0] rdData,
  output logic ackOk,
  output logic arbLost,
  // bus
  twowire_if.master bus
);
  typedef enum logic [3:0] {M_IDLE, M_WAITBUS, M_STA, M_RS1, M_RS2, M_LOW,
    M_HIGH, M_STO1, M_STO2} mst_t;
  typedef struct packed {
    logic sclM;
    logic sclS;
    logic sdaM;
    logic sdaS;
    logic sclPrev;
    logic sdaPrev;
    mst_t st;
    logic [CNT_W-1:0] cnt;
    logic [3:0] bitIdx;
    logic [8:0] txv;
    logic [8:0] rxv;
    logic isWrite;
    logic own;
    logic busBusy;
    logic sclLow;
    logic sdaLow;
    logic cmdReady;
    logic byteDone;
    logic [7:0] rdData;
    logic ackOk;
    logic arbLost;
  } mstate_t;
  mstate_t m_r;
  mstate_t m_nxt;
  logic startSeen;
  logic stopSeen;
  // bus conditions from synchronised samples
  assign startSeen = m_r.sclS & m_r.sclPrev & m_r.sdaPrev & ~m_r.sdaS;
  assign stopSeen = m_r.sclS & m_r.sclPrev & ~m_r.sdaPrev & m_r.sdaS;
  // next state
  always_comb
  begin
    m_nxt = m_r;
    m_nxt.sclM = bus.scl;
    m_nxt.sclS = m_r.sclM;
    m_nxt.sdaM = bus.sda;
    m_nxt.sdaS = m_r.sdaM;
    m_nxt.sclPrev = m_r.sclS;
    m_nxt.sdaPrev = m_r.sdaS;
    m_nxt.byteDone = 1'b0;
    m_nxt.arbLost = 1'b0;
    // idle tracking for bus access
    if (startSeen)
      m_nxt.busBusy = 1'b1;
    if (stopSeen)
      m_nxt.busBusy = 1'b0;
    if (rst)
    begin
      m_nxt.st = M_IDLE;
      m_nxt.cnt = '0;
      m_nxt.bitIdx = '0;
      m_nxt.own = 1'b0;
      m_nxt.busBusy = 1'b0;
      m_nxt.sclLow = 1'b0;
      m_nxt.sdaLow = 1'b0;
      m_nxt.cmdReady = 1'b0;
      m_nxt.rdData = '0;
      m_nxt.ackOk = 1'b0;
    end
    else
    begin
      case (m_r.st)
        M_IDLE:
        begin
          m_nxt.cmdReady = 1'b1;
          m_nxt.cnt = '0;
          m_nxt.bitIdx = '0;
          if (cmdValid && m_r.cmdReady)
          begin
            if (cmdKind == CMD_START)
            begin
              m_nxt.cmdReady = 1'b0;
              m_nxt.st = m_r.own ? M_RS1 : M_WAITBUS;
            end
            else if (m_r.own)
            begin
              m_nxt.cmdReady = 1'b0;
              m_nxt.isWrite = (cmdKind == CMD_WRITE);
              // msb first, ninth bit is the ack slot
              m_nxt.txv = (cmdKind == CMD_WRITE) ? {cmdData, 1'b1}
                : {IDLE_BYTE, cmdLast};
              m_nxt.st = (cmdKind == CMD_STOP) ? M_STO1 : M_LOW;
            end
          end
        end
        M_WAITBUS:
          // start only on an idle bus
          if (!m_r.busBusy && m_r.sclS && m_r.sdaS)
          begin
            m_nxt.sdaLow = 1'b1;
            m_nxt.st = M_STA;
          end
        M_STA:
        begin
          m_nxt.cnt = m_r.cnt + 1'b1;
          if (m_r.cnt == HIGH_LAST)
          begin
            m_nxt.sclLow = 1'b1;
            m_nxt.own = 1'b1;
            m_nxt.st = M_IDLE;
          end
        end
        M_RS1:
        begin
          // release sda while scl is low, then let scl rise
          m_nxt.sdaLow = 1'b0;
          m_nxt.cnt = m_r.cnt + 1'b1;
          if (m_r.cnt == LOW_LAST)
          begin
            m_nxt.sclLow = 1'b0;
            m_nxt.cnt = '0;
            m_nxt.st = M_RS2;
          end
        end
        M_RS2:
          if (m_r.sclS)
          begin
            m_nxt.cnt = m_r.cnt + 1'b1;
            if (m_r.cnt == HIGH_LAST)
            begin
              m_nxt.sdaLow = 1'b1;
              m_nxt.cnt = '0;
              m_nxt.st = M_STA;
            end
          end
        M_LOW:
        begin
          m_nxt.sclLow = 1'b1;
          m_nxt.sdaLow = ~m_r.txv[8];
          m_nxt.cnt = m_r.cnt + 1'b1;
          if (m_r.cnt == LOW_LAST)
          begin
            m_nxt.sclLow = 1'b0;
            m_nxt.cnt = '0;
            m_nxt.st = M_HIGH;
          end
        end
        M_HIGH:
        begin
          // high phase timed only once the line is really high
          if (m_r.sclS)
            m_nxt.cnt = m_r.cnt + 1'b1;
          if (m_r.sclS && m_r.isWrite && m_r.bitIdx < ACK_SLOT
              && m_r.txv[8] && !m_r.sdaS)
          begin
            // released high but saw low: back off
            m_nxt.sclLow = 1'b0;
            m_nxt.sdaLow = 1'b0;
            m_nxt.own = 1'b0;
            m_nxt.arbLost = 1'b1;
            m_nxt.st = M_IDLE;
          end
          else if ((m_r.sclS && m_r.cnt == HIGH_LAST)
              || (!m_r.sclS && m_r.cnt != '0))
          begin
            // end of high, or cut short by another master
            m_nxt.rxv = {m_r.rxv[7:0], m_r.sdaS};
            m_nxt.txv = {m_r.txv[7:0], 1'b1};
            m_nxt.bitIdx = m_r.bitIdx + 1'b1;
            m_nxt.sclLow = 1'b1;
            m_nxt.cnt = '0;
            m_nxt.st = M_LOW;
            if (m_r.bitIdx == ACK_SLOT)
            begin
              m_nxt.rdData = m_r.rxv[7:0];
              m_nxt.ackOk = ~m_r.sdaS;
              m_nxt.byteDone = 1'b1;
              m_nxt.st = M_IDLE;
            end
          end
        end
        M_STO1:
        begin
          m_nxt.sdaLow = 1'b1;
          m_nxt.cnt = m_r.cnt + 1'b1;
          if (m_r.cnt == LOW_LAST)
          begin
            m_nxt.sclLow = 1'b0;
            m_nxt.cnt = '0;
            m_nxt.st = M_STO2;
          end
        end
        M_STO2:
          if (m_r.sclS)
          begin
            m_nxt.cnt = m_r.cnt + 1'b1;
            if (m_r.cnt == HIGH_LAST)
            begin
              m_nxt.sdaLow = 1'b0;
              m_nxt.own = 1'b0;
              m_nxt.st = M_IDLE;
            end
          end
        default:
          m_nxt.st = M_IDLE;
      endcase
    end
  end
  // state register
  always_ff @(posedge clk)
  begin
    m_r <= m_nxt;
  end
  // outputs; pins only ever pull low
  assign cmdReady = m_r.cmdReady;
  assign byteDone = m_r.byteDone;
  assign rdData = m_r.rdData;
  assign ackOk = m_r.ackOk;
  assign arbLost = m_r.arbLost;
  assign bus.sclOutM = 1'b0;
  assign bus.sdaOutM = 1'b0;
  assign bus.sclOeM = m_r.sclLow;
  assign bus.sdaOeM = m_r.sdaLow;
endmodule
`default_nettype wire

// ---- bench/twowire_framing_sva.sv ----
/*
  concurrent checks on the open-drain carrier between master and slave.
  assumes the carrier signals are sampled on the 40 MHz master clock.
*/
`timescale 1ns/1ps
`default_nettype none
module twowire_framing_sva
  import twowire_pkg::*;
#(
  parameter logic [6:0] OWN_ADDR = DEF_ADDR
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // end drivers
  input wire logic sclOutM,
  input wire logic sclOeM,
  input wire logic sdaOutM,
  input wire logic sdaOeM,
  input wire logic sclOutD,
  input wire logic sclOeD,
  input wire logic sdaOutD,
  input wire logic sdaOeD,
  // wire levels
  input wire logic scl,
  input wire logic sda
);
  typedef struct packed {
    logic sclQ;
    logic sdaQ;
    logic addrPh;
    logic [3:0] bitCnt;
    logic [7:0] shift;
  } mon_t;
  mon_t mon_r;
  mon_t mon_nxt;
  logic startEv;
  logic stopEv;
  logic riseScl;
  logic ackSlot;
  // bus conditions against the previous sample
  assign startEv = scl & mon_r.sclQ & mon_r.sdaQ & ~sda;
  assign stopEv = scl & mon_r.sclQ & ~mon_r.sdaQ & sda;
  assign riseScl = scl & ~mon_r.sclQ;
  assign ackSlot = mon_r.addrPh & (mon_r.bitCnt == 4'h8) & ~scl & mon_r.sclQ;
  // address packet shifter, restarted by every start
  always_comb
  begin
    mon_nxt = mon_r;
    mon_nxt.sclQ = scl;
    mon_nxt.sdaQ = sda;
    if (startEv)
    begin
      mon_nxt.addrPh = 1'b1;
      mon_nxt.bitCnt = 4'h0;
    end
    else if (stopEv || (riseScl && mon_r.bitCnt == 4'h8))
      mon_nxt.addrPh = 1'b0;
    else if (riseScl)
    begin
      mon_nxt.shift = {mon_r.shift[6:0], sda};
      mon_nxt.bitCnt = mon_r.bitCnt + 4'h1;
    end
  end
  // monitor state register
  always_ff @(posedge clk)
  begin
    if (rst)
      mon_r <= '{sclQ: 1'b1, sdaQ: 1'b1, default: '0}; // idle level, no edge
    else
      mon_r <= mon_nxt;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  drive_low_a: assert property (!(sclOutM | sdaOutM | sclOutD | sdaOutD))
    else $error("an end drives a line high");
  start_clock_a: assert property (startEv |-> ##[1:400] !scl)
    else $error("no clock low after start");
  stop_release_a: assert property (stopEv |=> (!sdaOeD && !sclOeD) [*8])
    else $error("slave holds a line after stop");
  slave_hold_a: assert property ($changed(sdaOeD) |-> !scl)
    else $error("slave moved data while clock high");
  addr_ack_a: assert property (ackSlot && mon_r.shift[7:1] == OWN_ADDR
    |-> ##[1:40] (sdaOeD && !scl))
    else $error("own address not acknowledged");
  addr_nack_a: assert property (ackSlot && mon_r.shift[7:1] != OWN_ADDR
    |-> !sdaOeD [*8])
    else $error("foreign address acknowledged");
  stretch_low_a: assert property ($rose(sclOeD) |-> !$past(scl))
    else $error("clock held low before seen low");
  high_wait_a: assert property (riseScl |-> !sclOeM [*8])
    else $error("master cut clock high at once");
  start_c: cover property (startEv);
  ack_c: cover property (ackSlot);
  stop_c: cover property (stopEv);
endmodule
`default_nettype wire

// ---- bench/tb_two_wire_bus_slave_framing.sv ----
/*
  self-checking bench: master end and slave end joined by the carrier.
  assumes 40 MHz clk, free 80 ns link clock, commands one at a time.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_two_wire_bus_slave_framing;
  import twowire_pkg::*;
  localparam int STEP = 1;
  logic clk;
  logic linkClk;
  logic rst;
  logic cmdValid;
  cmd_t cmdKind;
  logic [7:0] cmdData;
  logic cmdLast;
  logic cmdReady;
  logic byteDone;
  logic [7:0] rdData;
  logic ackOk;
  logic arbLost;
  logic asleep;
  logic rxAck;
  logic txLoad;
  logic [7:0] txByte;
  logic txFree;
  logic rxValid;
  logic [7:0] rxByte;
  logic busy;
  logic [7:0] lastRd;
  logic lastAck;
  logic [7:0] rxQ[$];
  int stretchRun;
  int stretchMax;
  int arbCount;
  int n_fail;
  int cmp_count;
  twowire_if i_twowire_if();
  twowire_master i_twowire_master (.clk(clk), .rst(rst),
    .cmdValid(cmdValid), .cmdKind(cmdKind), .cmdData(cmdData),
    .cmdLast(cmdLast), .cmdReady(cmdReady), .byteDone(byteDone),
    .rdData(rdData), .ackOk(ackOk), .arbLost(arbLost),
    .bus(i_twowire_if.master));
  twowire_slave i_twowire_slave (.clk(clk), .linkClk(linkClk), .rst(rst),
    .asleep(asleep), .rxAck(rxAck), .txLoad(txLoad), .txByte(txByte),
    .txFree(txFree), .rxValid(rxValid), .rxByte(rxByte), .busy(busy),
    .bus(i_twowire_if.device));
  twowire_framing_sva i_twowire_framing_sva (.clk(clk), .rst(rst),
    .sclOutM(i_twowire_if.sclOutM), .sclOeM(i_twowire_if.sclOeM),
    .sdaOutM(i_twowire_if.sdaOutM), .sdaOeM(i_twowire_if.sdaOeM),
    .sclOutD(i_twowire_if.sclOutD), .sclOeD(i_twowire_if.sclOeD),
    .sdaOutD(i_twowire_if.sdaOutD), .sdaOeD(i_twowire_if.sdaOeD),
    .scl(i_twowire_if.scl), .sda(i_twowire_if.sda));
  // clocks, link clock offset in phase
  initial
  begin
    clk = 1'b0;
    forever #(CLK_PERIOD_NS / 2.0) clk = ~clk;
  end
  initial
  begin
    linkClk = 1'b0;
    #7;
    forever #(LINK_PERIOD_NS / 2) linkClk = ~linkClk;
  end
  // received bytes, arbitration losses and longest slave clock hold
  always @(posedge clk)
  begin
    #STEP;
    if (rxValid === 1'b1)
      rxQ.push_back(rxByte);
    if (arbLost === 1'b1)
      arbCount++;
    stretchRun = (i_twowire_if.sclOeD === 1'b1) ? stretchRun + 1 : 0;
    if (stretchRun > stretchMax)
      stretchMax = stretchRun;
  end
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk1(input logic got, input logic exp, input string what);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t %s got %b", $time, what, got);
    end
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t byte %h not %h", $time, got, exp);
    end
  endtask
  function automatic logic sigVal(input int k);
    case (k)
      0: return cmdReady;
      1: return byteDone;
      2: return txFree;
      default: return busy;
    endcase
  endfunction
  // bounded wait on a user side flag
  task automatic waitFor(input int k, input logic lvl);
    int n;
    n = 0;
    while (sigVal(k) !== lvl)
    begin
      @(posedge clk);
      #STEP;
      n++;
      if (n > 20000)
      begin
        n_fail++;
        $display("MISMATCH t=%0t wait %0d ran out", $time, k);
        summarize();
      end
    end
  endtask
  task automatic issue(input cmd_t k, input logic [7:0] d, input logic last);
    waitFor(0, 1'b1);
    cmdValid = 1'b1;
    cmdKind = k;
    cmdData = d;
    cmdLast = last;
    @(posedge clk);
    #STEP;
    cmdValid = 1'b0;
    if (k == CMD_WRITE || k == CMD_READ)
    begin
      waitFor(1, 1'b1);
      lastRd = rdData;
      lastAck = ackOk;
    end
  endtask
  task automatic load(input logic [7:0] b);
    waitFor(2, 1'b1);
    txLoad = 1'b1;
    txByte = b;
    @(posedge clk);
    #STEP;
    txLoad = 1'b0;
  endtask
  function automatic logic [7:0] popRx();
    return (rxQ.size() > 0) ? rxQ.pop_front() : 8'hxx;
  endfunction
  // write two bytes, the second refused by the slave
  task automatic scenWrite();
    issue(CMD_START, 8'h00, 1'b0);
    issue(CMD_WRITE, {DEF_ADDR, 1'b0}, 1'b0);
    chk1(lastAck, 1'b1, "address ack");
    issue(CMD_WRITE, 8'ha5, 1'b0);
    chk1(lastAck, 1'b1, "data ack");
    rxAck = 1'b0;
    issue(CMD_WRITE, 8'h3c, 1'b0);
    chk1(lastAck, 1'b0, "data nack");
    rxAck = 1'b1;
    issue(CMD_STOP, 8'h00, 1'b0);
    waitFor(3, 1'b0);
    chk8(popRx(), 8'ha5);
    chk8(popRx(), 8'h3c);
  endtask
  // foreign address, repeated start, address only
  task automatic scenRestart();
    issue(CMD_START, 8'h00, 1'b0);
    issue(CMD_WRITE, {DEF_ADDR ^ 7'h01, 1'b0}, 1'b0);
    chk1(lastAck, 1'b0, "foreign address");
    issue(CMD_START, 8'h00, 1'b0);
    issue(CMD_WRITE, {DEF_ADDR, 1'b0}, 1'b0);
    chk1(lastAck, 1'b1, "restart address");
    issue(CMD_STOP, 8'h00, 1'b0);
    waitFor(3, 1'b0);
    chk8(8'(rxQ.size()), 8'h00);
  endtask
  // master read of two bytes, last one refused
  task automatic scenRead();
    issue(CMD_START, 8'h00, 1'b0);
    issue(CMD_WRITE, {DEF_ADDR, 1'b1}, 1'b0);
    chk1(lastAck, 1'b1, "read address");
    repeat (20) @(posedge clk);
    #STEP;
    chk1(i_twowire_if.sclOeD, 1'b1, "byte wait hold");
    load(8'h96);
    load(8'h4b);
    issue(CMD_READ, 8'h00, 1'b0);
    chk8(lastRd, 8'h96);
    chk1(lastAck, 1'b1, "master ack");
    issue(CMD_READ, 8'h00, 1'b1);
    chk8(lastRd, 8'h4b);
    chk1(lastAck, 1'b0, "master nack");
    issue(CMD_STOP, 8'h00, 1'b0);
    waitFor(3, 1'b0);
  endtask
  // sleeping slave holds the clock through wake-up
  task automatic scenSleep();
    asleep = 1'b1;
    stretchMax = 0;
    issue(CMD_START, 8'h00, 1'b0);
    issue(CMD_WRITE, {DEF_ADDR, 1'b0}, 1'b0);
    asleep = 1'b0;
    chk1(lastAck, 1'b1, "wake address");
    chk1(stretchMax >= WAKE_NS / CLK_PERIOD_NS - 2, 1'b1, "wake hold");
    chk1(stretchMax <= WAKE_NS / CLK_PERIOD_NS + 2, 1'b1, "wake end");
    issue(CMD_STOP, 8'h00, 1'b0);
    waitFor(3, 1'b0);
  endtask
  // main sequence
  initial
  begin
    rst = 1'b1;
    cmdValid = 1'b0;
    cmdKind = CMD_START;
    cmdData = 8'h00;
    cmdLast = 1'b0;
    asleep = 1'b0;
    rxAck = 1'b1;
    txLoad = 1'b0;
    txByte = 8'h00;
    stretchRun = 0;
    stretchMax = 0;
    arbCount = 0;
    n_fail = 0;
    cmp_count = 0;
    repeat (12) @(posedge clk);
    #STEP;
    rst = 1'b0;
    repeat (4) @(posedge clk);
    #STEP;
    chk1(i_twowire_if.scl, 1'b1, "idle clock line");
    chk1(i_twowire_if.sda, 1'b1, "idle data line");
    scenWrite();
    scenRestart();
    scenRead();
    scenSleep();
    chk8(8'(arbCount), 8'h00);
    summarize();
  end
endmodule
`default_nettype wire
